// ### hdl/dma_cycle_timing_arbiter.sv
// four-channel cycle-stealing transfer engine with fixed-priority arbitration
//
// Function
// RL1: read source cycles then write destination cycles
// RL2: odd word source on 16-bit bus: extra read
// RL3: odd word destination on 16-bit bus: extra write
// RL4: word 8-bit both ends: two reads, two writes
// RL5: word 8-bit source, 16-bit destination: two, one
// RL6: word 16-bit source, 8-bit destination: one, two
// RL7: bus width bit 0 8-bit, 1 16-bit
// RL8: wait-state and register areas add wait clocks
// RL9: external cycles stretch while ready is low
// RL10: duration equals reads times j plus writes times k
// RL11: coefficients 1, 2, or external 2..9 plus recovery
// RL12: requests in one sample period latch together
// RL13: channel 0 first, then 1, 2, 3
// RL14: requester spaces requests by channels-1 times five
// RL15: release bus, wait one CPU access between transfers
// RL16: one pending flag, cleared on bus ownership
// RL17: counter one to zero raises completion request
// RL18: request bus, start after grant, return after write
`timescale 1ns/1ps
module dma_cycle_timing_arbiter
  import dma_cycle_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // per-channel requests and setup
  input wire logic [NUM_CHAN-1:0] request_in,
  input wire logic [NUM_CHAN-1:0] chan_enable_in,
  input wire logic [NUM_CHAN-1:0] repeat_mode_in,
  input wire logic [NUM_CHAN-1:0] transfer_unit_width_bit_in,
  input wire logic [NUM_CHAN-1:0] count_load_in,
  input wire logic [COUNT_W-1:0] count_value_in,
  input wire logic [COUNT_W-1:0] reload_value_in,
  // transfer description shared by all channels
  input wire logic [ADDR_W-1:0] src_addr_in,
  input wire logic [ADDR_W-1:0] dst_addr_in,
  input wire logic [1:0] src_area_in,
  input wire logic [1:0] dst_area_in,
  input wire logic src_bus_width_select_in,
  input wire logic dst_bus_width_select_in,
  input wire logic [3:0] src_ext_clocks_in,
  input wire logic [3:0] dst_ext_clocks_in,
  input wire logic src_recovery_in,
  input wire logic dst_recovery_in,
  input wire logic [3:0] sw_wait_clocks_in,
  input wire logic ext_mode_in,
  input wire logic ready_in,
  // bus ownership with cpu
  input wire logic bus_grant_in,
  input wire logic cpu_access_done_in,
  output logic bus_request_out,
  // bus cycle outputs
  output logic bus_read_out,
  output logic bus_write_out,
  output logic byte_access_out,
  output logic [ADDR_W-1:0] bus_addr_out,
  output logic [1:0] active_chan_out,
  output logic transfer_done_out,
  // status
  output logic [NUM_CHAN-1:0] request_pending_flag_out,
  output logic [NUM_CHAN-1:0] complete_irq_out,
  output logic [COUNT_W-1:0] transfer_counter_out [NUM_CHAN]
);

  ////////////////////////////////////////////////////////////////////////
  // functions

  // clocks per bus cycle for an area
  function automatic logic [4:0] cycle_clocks(input logic [1:0] area, input logic [3:0] ext_clk,
                                              input logic rec, input logic [3:0] sw_wait);
    logic [4:0] base;
    base = 5'h01;
    case (area)
      AREA_RAM: base = {1'b0, CLK_RAM};
      // RL8: software wait added
      AREA_RAM_WAIT, AREA_SFR: base = 5'({1'b0, CLK_WAIT} + {1'b0, sw_wait} - 5'h01) ;
      // RL11: external 2..9 plus recovery
      default: base = 5'({1'b0, (ext_clk < EXT_MIN_CLK) ? EXT_MIN_CLK :
                          (ext_clk > EXT_MAX_CLK) ? EXT_MAX_CLK : ext_clk} + {4'h0, rec});
    endcase
    return base;
  endfunction

  // bus cycles for one side of a word or byte transfer
  function automatic logic [1:0] cycle_count(input logic word, input logic [1:0] area,
                                             input logic width, input logic odd);
    logic [1:0] n;
    n = 2'h1;
    // RL7: narrow bus only in external area
    if (word == UNIT_WORD && ((area == AREA_EXT && width == WIDTH_8) || odd)) begin
      n = 2'h2;
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  eng_state_t state_q, state_d;
  logic [NUM_CHAN-1:0] pend_q, pend_d;
  logic [COUNT_W-1:0] count_q [NUM_CHAN];
  logic [COUNT_W-1:0] count_d [NUM_CHAN];
  logic [NUM_CHAN-1:0] irq_q, irq_d;
  logic [1:0] chan_q, chan_d;
  logic [1:0] left_q, left_d;
  logic [4:0] clk_q, clk_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic rd_q, rd_d, wr_q, wr_d, byte_q, byte_d, req_q, req_d, done_q, done_d;
  logic cpu_turn_q, cpu_turn_d;
  logic [NUM_CHAN-1:0] ready_chans;
  logic [1:0] pick;
  logic word_sel, ext_hold, side_ext;

  // channels eligible: pending, enabled and counter nonzero
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      ready_chans[i] = pend_q[i] && chan_enable_in[i] && (count_q[i] != COUNT_ZERO);
    end
    // RL13: lowest channel wins
    pick = 2'h0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (ready_chans[i]) begin
        pick = 2'(i);
      end
    end
  end

  assign word_sel = transfer_unit_width_bit_in[chan_q];
  // RL9: ready only stretches external cycles in external-bus mode
  assign side_ext = rd_q ? (src_area_in == AREA_EXT) : (dst_area_in == AREA_EXT);
  assign ext_hold = ext_mode_in && side_ext && !ready_in;

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_d = state_q;
    pend_d = pend_q;
    count_d = count_q;
    irq_d = '0;
    chan_d = chan_q;
    left_d = left_q;
    clk_d = clk_q;
    addr_d = addr_q;
    rd_d = rd_q;
    wr_d = wr_q;
    byte_d = byte_q;
    req_d = req_q;
    done_d = 1'b0;
    cpu_turn_d = cpu_turn_q;
    // RL15: one cpu access must finish before next transfer
    if (cpu_access_done_in) begin
      cpu_turn_d = 1'b0;
    end
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (count_load_in[i]) begin
        count_d[i] = count_value_in;
      end
    end
    case (state_q)
      ST_IDLE: begin
        if (ready_chans != '0 && !cpu_turn_q) begin
          chan_d = pick;
          // RL18: ask for the bus first
          req_d = 1'b1;
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (bus_grant_in) begin
          // RL16: flag clears on ownership
          pend_d[chan_q] = 1'b0;
          // RL1: source read first
          // RL2: odd source word
          // RL4: two byte reads when narrow
          left_d = cycle_count(word_sel, src_area_in, src_bus_width_select_in, src_addr_in[0]);
          clk_d = cycle_clocks(src_area_in, src_ext_clocks_in, src_recovery_in, sw_wait_clocks_in);
          addr_d = src_addr_in;
          byte_d = (word_sel == UNIT_BYTE) || (left_d == 2'h2);
          rd_d = 1'b1;
          state_d = ST_READ;
        end
      end
      ST_READ, ST_WRITE: begin
        // RL10: each bus cycle costs its coefficient in clocks
        if (clk_q > 5'h01 || ext_hold) begin
          clk_d = (clk_q > 5'h01) ? 5'(clk_q - 5'h01) : clk_q;
        end else if (left_q > 2'h1) begin
          left_d = 2'(left_q - 2'h1);
          addr_d = ADDR_W'(addr_q + 1'b1);
          clk_d = (state_q == ST_READ) ?
                  cycle_clocks(src_area_in, src_ext_clocks_in, src_recovery_in, sw_wait_clocks_in) :
                  cycle_clocks(dst_area_in, dst_ext_clocks_in, dst_recovery_in, sw_wait_clocks_in);
        end else if (state_q == ST_READ) begin
          // RL3: odd destination word
          // RL5: word write after two byte reads
          // RL6: two byte writes after word read
          left_d = cycle_count(word_sel, dst_area_in, dst_bus_width_select_in, dst_addr_in[0]);
          clk_d = cycle_clocks(dst_area_in, dst_ext_clocks_in, dst_recovery_in, sw_wait_clocks_in);
          addr_d = dst_addr_in;
          byte_d = (word_sel == UNIT_BYTE) || (left_d == 2'h2);
          rd_d = 1'b0;
          wr_d = 1'b1;
          state_d = ST_WRITE;
        end else begin
          wr_d = 1'b0;
          // RL18: grant returned after write
          req_d = 1'b0;
          done_d = 1'b1;
          cpu_turn_d = 1'b1;
          // RL17: one to zero raises completion
          if (count_q[chan_q] == COUNT_ONE) begin
            irq_d[chan_q] = 1'b1;
            count_d[chan_q] = repeat_mode_in[chan_q] ? reload_value_in : COUNT_ZERO;
          end else begin
            count_d[chan_q] = COUNT_W'(count_q[chan_q] - COUNT_ONE);
          end
          state_d = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // RL12: all requests in a sample latch together, set wins
    pend_d = pend_d | request_in;
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_q <= ST_IDLE;
      pend_q <= PEND_RESET;
      for (int i = 0; i < NUM_CHAN; i++) begin
        count_q[i] <= COUNT_ZERO;
      end
      irq_q <= '0;
      chan_q <= 2'h0;
      left_q <= 2'h0;
      clk_q <= 5'h00;
      addr_q <= '0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      byte_q <= 1'b0;
      req_q <= 1'b0;
      done_q <= 1'b0;
      cpu_turn_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pend_q <= pend_d;
      count_q <= count_d;
      irq_q <= irq_d;
      chan_q <= chan_d;
      left_q <= left_d;
      clk_q <= clk_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      byte_q <= byte_d;
      req_q <= req_d;
      done_q <= done_d;
      cpu_turn_q <= cpu_turn_d;
    end
  end

  // outputs straight from flops
  assign bus_request_out = req_q;
  assign bus_read_out = rd_q;
  assign bus_write_out = wr_q;
  assign byte_access_out = byte_q;
  assign bus_addr_out = addr_q;
  assign active_chan_out = chan_q;
  assign transfer_done_out = done_q;
  assign request_pending_flag_out = pend_q;
  assign complete_irq_out = irq_q;
  assign transfer_counter_out = count_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  chk_read_before_write: assert property (wr_q && !$past(wr_q) |-> $past(rd_q)) // RL1
    else $error("write began without a preceding read");
  chk_no_both_cycles: assert property (!(rd_q && wr_q)) // RL1
    else $error("read and write active together");
  chk_grant_first: assert property ($rose(rd_q) |-> $past(bus_grant_in) && $past(req_q)) // RL18
    else $error("read started without grant");
  chk_request_latch: assert property (request_in[1] |=> pend_q[1] || rd_q || state_q == ST_READ) // RL12
    else $error("request not latched");
  chk_pending_clear: assert property (state_q == ST_HOLD && bus_grant_in && !request_in[chan_q]
                                      |=> !pend_q[$past(chan_q)]) // RL16
    else $error("pending flag not cleared on ownership");
  chk_priority_zero: assert property (state_q == ST_IDLE && ready_chans[0] && !cpu_turn_q
                                      |=> chan_q == 2'h0) // RL13
    else $error("channel zero not first");
  chk_cpu_turn: assert property (done_q |-> state_q == ST_RELEASE ##1 state_q == ST_IDLE) // RL15
    else $error("engine did not release bus");
  chk_ram_timing: assert property ($rose(rd_q) && clk_q == 5'h01 && left_q == 2'h1 |=> $fell(rd_q)) // RL10
    else $error("single-clock read took wrong length");
  chk_irq_cause: assert property (irq_q != '0 |-> $past(done_d)) // RL17
    else $error("completion without transfer end");
  chk_ready_wait: assert property (rd_q && ext_hold && clk_q == 5'h01 |=> rd_q && addr_q == $past(addr_q)) // RL9
    else $error("cycle ended while not ready");

  cov_word_odd: cover property ($rose(rd_q) && left_q == 2'h2);
  cov_two_pending: cover property (pend_q[0] && pend_q[1]);
  cov_complete: cover property (irq_q != '0);

endmodule

// ### hdl/dma_cycle_pkg.sv
// package of constants and types for the cycle-stealing transfer engine
package dma_cycle_pkg;
  localparam int unsigned NUM_CHAN = 4;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned COUNT_W = 16;
  // area codes for source and destination
  localparam logic [1:0] AREA_RAM = 2'h0;
  localparam logic [1:0] AREA_RAM_WAIT = 2'h1;
  localparam logic [1:0] AREA_SFR = 2'h2;
  localparam logic [1:0] AREA_EXT = 2'h3;
  // clocks per bus cycle by area
  localparam logic [3:0] CLK_RAM = 4'h1;
  localparam logic [3:0] CLK_WAIT = 4'h2;
  localparam logic [3:0] EXT_MIN_CLK = 4'h2;
  localparam logic [3:0] EXT_MAX_CLK = 4'h9;
  // bus width select: 0 = 8-bit, 1 = 16-bit
  localparam logic WIDTH_8 = 1'b0;
  localparam logic WIDTH_16 = 1'b1;
  // transfer unit width bit: 0 = byte, 1 = word
  localparam logic UNIT_BYTE = 1'b0;
  localparam logic UNIT_WORD = 1'b1;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [3:0] PEND_RESET = 4'h0;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HOLD,
    ST_READ,
    ST_WRITE,
    ST_RELEASE
  } eng_state_t;
endpackage

// ### tb/cpu_bus_model.sv
// cpu side of the shared bus: grant, one cpu access per release, ready stalls
`timescale 1ns/1ps
module cpu_bus_model (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // engine side
  input wire logic bus_request_in,
  input wire logic bus_read_in,
  input wire logic bus_write_in,
  input wire logic transfer_done_in,
  input wire logic [2:0] gap_in,
  input wire logic [3:0] stall_in,
  // answers to the engine
  output logic bus_grant_out,
  output logic cpu_access_done_out,
  output logic ready_out
);
  logic [2:0] g_q, a_q;
  logic [3:0] stall_q, left;
  logic owed_q, rd_q, tog_q;
  // ready low for the first cycles of a read; writes never stall, idle it toggles
  assign left = (bus_read_in && !rd_q) ? stall_in : stall_q;
  // a leftover stall count must not leak into the write that follows a short read
  assign ready_out = bus_read_in ? (left == 4'h0) : (bus_write_in || tog_q);
  // grant after gap_in cycles, one cpu access after each release
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      {bus_grant_out, cpu_access_done_out, owed_q, rd_q, tog_q} <= '0;
      {g_q, a_q, stall_q} <= '0;
    end else begin
      rd_q <= bus_read_in;
      tog_q <= ~tog_q;
      stall_q <= (bus_read_in && left != 4'h0) ? left - 4'h1 : 4'h0;
      cpu_access_done_out <= 1'b0;
      g_q <= 3'h0;
      if (!bus_request_in) bus_grant_out <= 1'b0;
      else if (!bus_grant_out && g_q == gap_in) bus_grant_out <= 1'b1;
      else if (!bus_grant_out) g_q <= g_q + 3'h1;
      if (transfer_done_in) owed_q <= 1'b1;
      a_q <= owed_q ? a_q + 3'h1 : 3'h0;
      if (owed_q && a_q == gap_in) begin
        cpu_access_done_out <= 1'b1;
        owed_q <= 1'b0;
      end
    end
  end
endmodule

// ### tb/tb_top.sv
// self-checking bench for the cycle-stealing transfer engine
`timescale 1ns/1ps
module tb_top;
  import dma_cycle_pkg::*;
  logic clock_in = 0, srst_in = 1, ext_mode_in = 0, src_recovery_in = 0, dst_recovery_in = 0;
  logic src_bus_width_select_in = 1, dst_bus_width_select_in = 1, ready_in, bus_grant_in, cpu_access_done_in;
  logic [3:0] request_in = 0, chan_enable_in = 4'hF, repeat_mode_in = 4'h4, count_load_in = 0;
  logic [3:0] transfer_unit_width_bit_in = 0, src_ext_clocks_in = 2, dst_ext_clocks_in = 2, sw_wait_clocks_in = 1;
  logic [15:0] count_value_in = 0, reload_value_in = 16'h0005;
  logic [23:0] src_addr_in = 0, dst_addr_in = 0, bus_addr_out;
  logic [1:0] src_area_in = 0, dst_area_in = 0, active_chan_out;
  logic bus_request_out, bus_read_out, bus_write_out, byte_access_out, transfer_done_out, owed = 0;
  logic [3:0] request_pending_flag_out, complete_irq_out, irq_seen, stall = 0;
  logic [15:0] transfer_counter_out [4], exp_cnt [4];
  logic [2:0] gap = 0;
  int num_errors = 0, checks = 0;
  dma_cycle_timing_arbiter i_dma_cycle_timing_arbiter (.clock_in, .srst_in, .request_in, .chan_enable_in,
    .repeat_mode_in, .transfer_unit_width_bit_in, .count_load_in, .count_value_in, .reload_value_in, .src_addr_in,
    .dst_addr_in, .src_area_in, .dst_area_in, .src_bus_width_select_in, .dst_bus_width_select_in, .src_ext_clocks_in,
    .dst_ext_clocks_in, .src_recovery_in, .dst_recovery_in, .sw_wait_clocks_in, .ext_mode_in, .ready_in,
    .bus_grant_in, .cpu_access_done_in, .bus_request_out, .bus_read_out, .bus_write_out, .byte_access_out,
    .bus_addr_out, .active_chan_out, .transfer_done_out, .request_pending_flag_out, .complete_irq_out,
    .transfer_counter_out);
  cpu_bus_model i_cpu_bus_model (.clock_in, .srst_in, .bus_request_in(bus_request_out), .bus_read_in(bus_read_out),
    .bus_write_in(bus_write_out), .transfer_done_in(transfer_done_out), .gap_in(gap), .stall_in(stall),
    .bus_grant_out(bus_grant_in), .cpu_access_done_out(cpu_access_done_in), .ready_out(ready_in));
  initial forever #2 clock_in = ~clock_in;
  ////////////////////////////////////////////////////////////////////////////
  // clocks of one bus cycle by area
  function automatic int clks(logic [1:0] a, logic [3:0] e, logic r, logic [3:0] s);
    if (a == AREA_RAM) return 1;
    if (a != AREA_EXT) return 1 + s;
    return (e < EXT_MIN_CLK ? 2 : e > EXT_MAX_CLK ? 9 : e) + r;
  endfunction
  // bus cycles of one unit: odd word or narrow external area needs two
  function automatic int cyc(logic w, logic [1:0] a, logic bw, logic odd);
    return (w && (odd || (a == AREA_EXT && bw == WIDTH_8))) ? 2 : 1;
  endfunction
  task automatic cmp(logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // watch one transfer: channel, cycle counts and first addresses
  task automatic wait_xfer(input int c);
    int rc, wc, er, n;
    logic [23:0] ra, wa;
    logic irq;
    rc = 0;
    wc = 0;
    irq_seen = 0;
    for (int i = 0; i < 400 && !(i > 0 && transfer_done_out); i++) begin
      @(negedge clock_in);
      irq_seen |= complete_irq_out;
      if (bus_read_out && rc == 0) cmp(active_chan_out, c);
      if (bus_read_out && rc == 0) cmp(request_pending_flag_out[c], 0);
      if (bus_read_out && rc == 0) cmp(byte_access_out, !transfer_unit_width_bit_in[c]
        || cyc(transfer_unit_width_bit_in[c], src_area_in, src_bus_width_select_in, src_addr_in[0]) == 2);
      if (bus_read_out && rc == 0) ra = bus_addr_out;
      if (bus_write_out && wc == 0) wa = bus_addr_out;
      rc += bus_read_out;
      wc += bus_write_out;
    end
    n = clks(src_area_in, src_ext_clocks_in, src_recovery_in, sw_wait_clocks_in);
    er = cyc(transfer_unit_width_bit_in[c], src_area_in, src_bus_width_select_in, src_addr_in[0]) * n;
    // ready is only looked at once the first read's own countdown is spent
    if (ext_mode_in && src_area_in == AREA_EXT && stall + 1 > n) er += stall + 1 - n;
    cmp(rc, er);
    cmp(wc, cyc(transfer_unit_width_bit_in[c], dst_area_in, dst_bus_width_select_in, dst_addr_in[0])
      * clks(dst_area_in, dst_ext_clocks_in, dst_recovery_in, sw_wait_clocks_in));
    cmp(ra, src_addr_in);
    cmp(wa, dst_addr_in);
    irq = (exp_cnt[c] == COUNT_ONE);
    exp_cnt[c] = (irq && repeat_mode_in[c]) ? reload_value_in : exp_cnt[c] - 16'h1;
    cmp(transfer_counter_out[c], exp_cnt[c]);
    cmp(irq_seen[c], irq);
  endtask
  // random setup, one request pulse, then watch the transfer
  task automatic run_one(input int c);
    repeat (15) @(posedge clock_in);
    {src_area_in, dst_area_in, src_bus_width_select_in, dst_bus_width_select_in} <= 6'($urandom);
    {src_recovery_in, dst_recovery_in, ext_mode_in, gap} <= 6'($urandom);
    {src_addr_in, src_ext_clocks_in, dst_ext_clocks_in} <= 32'($urandom);
    dst_addr_in <= 24'($urandom);
    sw_wait_clocks_in <= 4'($urandom_range(1, 15));
    transfer_unit_width_bit_in <= 4'($urandom);
    stall <= 4'($urandom_range(0, 5));
    // one request at a time, a transfer plus (4-1)*5 clocks after the last
    request_in[c] <= 1'b1;
    @(posedge clock_in);
    request_in <= 4'h0;
    wait_xfer(c);
  endtask
  // no bus request may appear for a while
  task automatic quiet;
    logic seen;
    seen = 0;
    repeat (30) @(negedge clock_in) seen |= bus_request_out;
    cmp(seen, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // rising bus request while a cpu access is still owed
  always @(negedge clock_in) begin
    if (bus_request_out && !owed && transfer_done_out) owed = 1;
    else if (transfer_done_out) owed = 1;
    if (cpu_access_done_in) owed = 0;
    if (bus_request_out && owed) cmp(owed, 0);
  end
  initial begin
    #(4 * 40000);
    num_errors++;
    close_out();
  end
  initial begin
    void'($urandom(32'hF0CF28DC));
    repeat (6) @(posedge clock_in);
    srst_in <= 1'b0;
    @(posedge clock_in);
    count_value_in <= 16'h0100;
    count_load_in <= 4'hF;
    exp_cnt = '{16'h0100, 16'h0100, 16'h0100, 16'h0100};
    @(posedge clock_in);
    count_load_in <= 4'h0;
    request_in <= 4'hF;
    @(posedge clock_in);
    request_in <= 4'h0;
    @(negedge clock_in);
    cmp(request_pending_flag_out, 4'hF);
    for (int k = 0; k < 4; k++) wait_xfer(k);
    gap <= 3'h3;
    @(posedge clock_in);
    request_in <= 4'h2;
    @(posedge clock_in);
    request_in <= 4'h0;
    @(posedge clock_in);
    request_in <= 4'h2;
    @(posedge clock_in);
    request_in <= 4'h0;
    wait_xfer(1);
    quiet();
    repeat (40) run_one($urandom_range(0, 3));
    @(posedge clock_in);
    count_value_in <= COUNT_ONE;
    count_load_in <= 4'hC;
    exp_cnt[2] = COUNT_ONE;
    exp_cnt[3] = COUNT_ONE;
    @(posedge clock_in);
    count_load_in <= 4'h0;
    run_one(2);
    run_one(3);
    @(posedge clock_in);
    request_in <= 4'h8;
    @(posedge clock_in);
    request_in <= 4'h0;
    quiet();
    close_out();
  end
endmodule
